// File: core/mixer_gain_cfg.svh
// constants for the mixer gain control register bank
//
// Functional notes
// - control bit 7 enables input mixer two amplifier
// - control bit 6 mutes it, reset muted
// - ramp bit 5 and zero cross bit 4 both clear: gain applied at once
// - ramp and zero cross both set: ramp wins
// - zero cross bit 4 defers gain change
// - control bit 3 enables mixer, resets one
// - four-bit gain, 1.5 dB steps, reset 0x3
// - left output amplifier enable on bit 7
// - right output amplifier enable on bit 7
// - output gain 01/10/11, 00 reserved, reset 0x3
// - enabled equalizer adds fixed 12 dB attenuation
`ifndef MIXER_GAIN_CFG_SVH
`define MIXER_GAIN_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OUTPUT_HIGHPASS_CONFIG_OFS 8'h24
`define OUTPUT_EQ_BANDS_ONE_TWO_OFS 8'h25
`define OUTPUT_EQ_BANDS_THREE_FOUR_OFS 8'h26
`define OUTPUT_EQ_BAND_FIVE_ENABLE_OFS 8'h27
`define OUTPUT_BIQUAD_CONTROL_OFS 8'h28
`define OUTPUT_BIQUAD_COEF_DATA_OFS 8'h29
`define OUTPUT_BIQUAD_COEF_INDEX_OFS 8'h2a
`define INPUT_MIXER_TWO_CONTROL_OFS 8'h2e
`define INPUT_MIXER_TWO_GAIN_OFS 8'h2f
`define LEFT_OUTPUT_MIXER_CONTROL_OFS 8'hcc
`define LEFT_OUTPUT_MIXER_GAIN_OFS 8'hcd
`define RIGHT_OUTPUT_MIXER_CONTROL_OFS 8'hce
`define RIGHT_OUTPUT_MIXER_GAIN_OFS 8'hcf

// ----------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------
`define HPF_RST 8'h80
`define HPF_MSK 8'hbf
`define EQ_PAIR_RST 8'h77
`define EQ_PAIR_MSK 8'hff
`define EQ5_RST 8'h07
`define EQ5_MSK 8'h8f
`define BIQ_CTRL_RST 8'h40
`define BIQ_CTRL_MSK 8'hc0
`define BIQ_DATA_RST 8'h00
`define BIQ_DATA_MSK 8'hff
`define BIQ_INDEX_RST 8'h00
`define BIQ_INDEX_MSK 8'h3f
`define MIXIN2_CTRL_RST 8'h48
`define MIXIN2_CTRL_MSK 8'hf8
`define MIXIN2_GAIN_RST 8'h03
`define MIXIN2_GAIN_MSK 8'h0f
`define MIXOUT_CTRL_RST 8'h00
`define MIXOUT_CTRL_MSK 8'h80
`define MIXOUT_GAIN_RST 8'h03
`define MIXOUT_GAIN_MSK 8'h03
`define ZERO_BYTE 8'h00

// ----------------------------------------------------------------
// field positions, codes and counts
// ----------------------------------------------------------------
`define AMP_EN_BIT 7
`define MUTE_BIT 6
`define RAMP_BIT 5
`define ZC_BIT 4
`define MIX_SEL_BIT 3
`define EQ_ON_BIT 7
`define BIQ_ON_BIT 7
`define BIQ_MUTE_BIT 6
`define MIXIN2_GAIN_RST4 4'h3
`define MIXOUT_GAIN_RST2 2'h3
`define MIXOUT_GAIN_RSVD 2'h0
`define EQ_ATTEN_DB 4'hc
`define NO_ATTEN_DB 4'h0
`define RAMP_STEP_CYCLES 16

`endif

// File: core/mixer_gain_pkg.sv
// types shared by the mixer gain control register bank
`include "mixer_gain_cfg.svh"
package mixer_gain_pkg;
    typedef logic [7:0] byte_t;
    // gray coded along idle -> ramping -> zero cross wait
    typedef enum logic [1:0] {
        GP_IDLE = 2'b00,
        GP_RAMP = 2'b01,
        GP_ZC_WAIT = 2'b11
    } gain_state_e;
    typedef enum logic [3:0] {
        R_HPF, R_EQ12, R_EQ34, R_EQ5, R_BIQ_CTRL, R_BIQ_DATA, R_BIQ_INDEX,
        R_MIXIN2_CTRL, R_MIXIN2_GAIN, R_MIXL_CTRL, R_MIXL_GAIN,
        R_MIXR_CTRL, R_MIXR_GAIN, R_NONE
    } reg_idx_e;
endpackage

// File: core/input_gain_path.sv
// gain update engine of input mixer two: immediate, ramped or zero cross
`timescale 1ns/1ps
`include "mixer_gain_cfg.svh"
module input_gain_path
    import mixer_gain_pkg::*;
#(
    parameter int STEP_CYCLES = `RAMP_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [3:0] target,
    input wire logic ramp_on,
    input wire logic zc_on,
    input wire logic zero_cross,
    output logic [3:0] applied,
    output logic busy
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    gain_state_e state, next_state;
    logic [3:0] next_applied;
    logic [CW-1:0] tick, next_tick;

    // next state: ramp has priority over zero cross
    always_comb begin
        next_state = state;
        next_applied = applied;
        next_tick = tick;
        unique case (state)
            GP_IDLE: begin
                if (target != applied) begin
                    if (ramp_on) begin
                        next_state = GP_RAMP;
                        next_tick = CW'(STEP_CYCLES - 1);
                    end else if (zc_on) begin
                        next_state = GP_ZC_WAIT;
                    end else begin
                        next_applied = target;
                    end
                end
            end
            GP_RAMP: begin
                if (target == applied) begin
                    next_state = GP_IDLE;
                end else if (tick != '0) begin
                    next_tick = tick - CW'(1);
                end else begin
                    next_applied = (target > applied) ? applied + 4'h1 : applied - 4'h1;
                    next_tick = CW'(STEP_CYCLES - 1);
                end
            end
            GP_ZC_WAIT: begin
                if (ramp_on || !zc_on) begin
                    next_state = GP_IDLE;
                end else if (zero_cross) begin
                    next_applied = target;
                    next_state = GP_IDLE;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= GP_IDLE;
            applied <= `MIXIN2_GAIN_RST4;
            tick <= '0;
        end else begin
            state <= next_state;
            applied <= next_applied;
            tick <= next_tick;
        end
    end

    assign busy = (state != GP_IDLE);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_instant_apply;
        (state == GP_IDLE) && !ramp_on && !zc_on && (target != applied) |=> applied == $past(target);
    endproperty
    a_instant_apply: assert property (p_instant_apply) else $error("gain not applied at once");
    property p_zc_hold;
        (state == GP_ZC_WAIT) && zc_on && !ramp_on && !zero_cross |=> $stable(applied);
    endproperty
    a_zc_hold: assert property (p_zc_hold) else $error("gain moved before zero cross");
    property p_ramp_wins;
        (state == GP_IDLE) && ramp_on && zc_on && (target != applied) |=> (state == GP_RAMP) ##0 $stable(applied);
    endproperty
    a_ramp_wins: assert property (p_ramp_wins) else $error("ramp did not override zero cross");
endmodule // input_gain_path

// File: core/output_mixer_channel.sv
// one output mixer amplifier: enable and gain decode
`timescale 1ns/1ps
`include "mixer_gain_cfg.svh"
module output_mixer_channel (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic en_bit,
    input wire logic [1:0] gain_code,
    output logic amp_on,
    output logic [1:0] gain
);
    logic next_amp_on;
    logic [1:0] next_gain;

    // reserved code keeps the last legal gain
    always_comb begin
        next_amp_on = en_bit;
        next_gain = (gain_code == `MIXOUT_GAIN_RSVD) ? gain : gain_code;
    end

    // output registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_on <= 1'b0;
            gain <= `MIXOUT_GAIN_RST2;
        end else begin
            amp_on <= next_amp_on;
            gain <= next_gain;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_gain_legal;
        gain != `MIXOUT_GAIN_RSVD;
    endproperty
    a_gain_legal: assert property (p_gain_legal) else $error("reserved output gain applied");
endmodule // output_mixer_channel

// File: core/mixer_gain_control_regs.sv
// register bank for input mixer two, output mixers and output filter setup
`timescale 1ns/1ps
`include "mixer_gain_cfg.svh"
module mixer_gain_control_regs
    import mixer_gain_pkg::*;
#(
    parameter int RAMP_STEP_CYCLES = `RAMP_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic mixin2_zero_cross,
    output logic mixin2_amp_on,
    output logic mixin2_muted,
    output logic mixin2_mixer_on,
    output logic [3:0] mixin2_gain,
    output logic mixin2_gain_busy,
    output logic mixout_l_on,
    output logic [1:0] mixout_l_gain,
    output logic mixout_r_on,
    output logic [1:0] mixout_r_gain,
    output logic [7:0] highpass_cfg,
    output logic [19:0] eq_band_codes,
    output logic output_equalizer_on,
    output logic [3:0] eq_atten_db,
    output logic biquad_on,
    output logic biquad_muted,
    output logic [7:0] coef_data,
    output logic [5:0] coef_index,
    output logic coef_wr_pulse
);
    localparam int REG_COUNT = int'(R_NONE);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // address to register slot, R_NONE when unmapped
    function automatic reg_idx_e decode_addr(input logic [7:0] a);
        case (a)
            `OUTPUT_HIGHPASS_CONFIG_OFS: return R_HPF;
            `OUTPUT_EQ_BANDS_ONE_TWO_OFS: return R_EQ12;
            `OUTPUT_EQ_BANDS_THREE_FOUR_OFS: return R_EQ34;
            `OUTPUT_EQ_BAND_FIVE_ENABLE_OFS: return R_EQ5;
            `OUTPUT_BIQUAD_CONTROL_OFS: return R_BIQ_CTRL;
            `OUTPUT_BIQUAD_COEF_DATA_OFS: return R_BIQ_DATA;
            `OUTPUT_BIQUAD_COEF_INDEX_OFS: return R_BIQ_INDEX;
            `INPUT_MIXER_TWO_CONTROL_OFS: return R_MIXIN2_CTRL;
            `INPUT_MIXER_TWO_GAIN_OFS: return R_MIXIN2_GAIN;
            `LEFT_OUTPUT_MIXER_CONTROL_OFS: return R_MIXL_CTRL;
            `LEFT_OUTPUT_MIXER_GAIN_OFS: return R_MIXL_GAIN;
            `RIGHT_OUTPUT_MIXER_CONTROL_OFS: return R_MIXR_CTRL;
            `RIGHT_OUTPUT_MIXER_GAIN_OFS: return R_MIXR_GAIN;
            default: return R_NONE;
        endcase
    endfunction

    // writable bits of each slot; reserved bits store and read zero
    function automatic byte_t reg_mask(input reg_idx_e i);
        case (i)
            R_HPF: return `HPF_MSK;
            R_EQ12, R_EQ34: return `EQ_PAIR_MSK;
            R_EQ5: return `EQ5_MSK;
            R_BIQ_CTRL: return `BIQ_CTRL_MSK;
            R_BIQ_DATA: return `BIQ_DATA_MSK;
            R_BIQ_INDEX: return `BIQ_INDEX_MSK;
            R_MIXIN2_CTRL: return `MIXIN2_CTRL_MSK;
            R_MIXIN2_GAIN: return `MIXIN2_GAIN_MSK;
            R_MIXL_CTRL, R_MIXR_CTRL: return `MIXOUT_CTRL_MSK;
            R_MIXL_GAIN, R_MIXR_GAIN: return `MIXOUT_GAIN_MSK;
            default: return `ZERO_BYTE;
        endcase
    endfunction

    // reset value of each slot
    function automatic byte_t reg_reset(input reg_idx_e i);
        case (i)
            R_HPF: return `HPF_RST;
            R_EQ12, R_EQ34: return `EQ_PAIR_RST;
            R_EQ5: return `EQ5_RST;
            R_BIQ_CTRL: return `BIQ_CTRL_RST;
            R_BIQ_DATA: return `BIQ_DATA_RST;
            R_BIQ_INDEX: return `BIQ_INDEX_RST;
            R_MIXIN2_CTRL: return `MIXIN2_CTRL_RST;
            R_MIXIN2_GAIN: return `MIXIN2_GAIN_RST;
            R_MIXL_CTRL, R_MIXR_CTRL: return `MIXOUT_CTRL_RST;
            R_MIXL_GAIN, R_MIXR_GAIN: return `MIXOUT_GAIN_RST;
            default: return `ZERO_BYTE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    byte_t regs [REG_COUNT];
    byte_t next_regs [REG_COUNT];
    reg_idx_e acc_idx;
    byte_t next_rdata;
    logic next_rdata_valid;
    logic next_coef_wr_pulse;
    logic [3:0] next_eq_atten_db;

    // write path stores masked data, read path samples before the write
    always_comb begin
        acc_idx = decode_addr(reg_addr);
        next_regs = regs;
        next_coef_wr_pulse = 1'b0;
        if (reg_wr_en && acc_idx != R_NONE) begin
            next_regs[acc_idx] = reg_wdata & reg_mask(acc_idx);
            next_coef_wr_pulse = (acc_idx == R_BIQ_DATA);
        end
        next_rdata_valid = reg_rd_en;
        next_rdata = `ZERO_BYTE;
        if (reg_rd_en && acc_idx != R_NONE) begin
            next_rdata = regs[acc_idx];
        end
    end

    // fixed equalizer attenuation reported to the output filter gain stage
    always_comb begin
        next_eq_atten_db = regs[R_EQ5][`EQ_ON_BIT] ? `EQ_ATTEN_DB : `NO_ATTEN_DB;
    end

    // register file and read port flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= reg_reset(reg_idx_e'(i));
            end
            reg_rdata <= `ZERO_BYTE;
            reg_rdata_valid <= 1'b0;
            coef_wr_pulse <= 1'b0;
            eq_atten_db <= `NO_ATTEN_DB;
        end else begin
            regs <= next_regs;
            reg_rdata <= next_rdata;
            reg_rdata_valid <= next_rdata_valid;
            coef_wr_pulse <= next_coef_wr_pulse;
            eq_atten_db <= next_eq_atten_db;
        end
    end

    // ----------------------------------------------------------------
    // control fields to the signal path
    // ----------------------------------------------------------------

    // input mixer two switches straight from register bits
    assign mixin2_amp_on = regs[R_MIXIN2_CTRL][`AMP_EN_BIT];
    assign mixin2_muted = regs[R_MIXIN2_CTRL][`MUTE_BIT];
    assign mixin2_mixer_on = regs[R_MIXIN2_CTRL][`MIX_SEL_BIT];

    // output filter setup fields
    assign highpass_cfg = regs[R_HPF];
    assign eq_band_codes = {regs[R_EQ5][3:0], regs[R_EQ34], regs[R_EQ12]};
    assign output_equalizer_on = regs[R_EQ5][`EQ_ON_BIT];
    assign biquad_on = regs[R_BIQ_CTRL][`BIQ_ON_BIT];
    assign biquad_muted = regs[R_BIQ_CTRL][`BIQ_MUTE_BIT];
    assign coef_data = regs[R_BIQ_DATA];
    assign coef_index = regs[R_BIQ_INDEX][5:0];

    // gain update engine for input mixer two
    input_gain_path #(
        .STEP_CYCLES(RAMP_STEP_CYCLES)
    ) u_in_gain (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .target(regs[R_MIXIN2_GAIN][3:0]),
        .ramp_on(regs[R_MIXIN2_CTRL][`RAMP_BIT]),
        .zc_on(regs[R_MIXIN2_CTRL][`ZC_BIT]),
        .zero_cross(mixin2_zero_cross),
        .applied(mixin2_gain),
        .busy(mixin2_gain_busy)
    );

    // left output mixer amplifier
    output_mixer_channel u_mix_l (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .en_bit(regs[R_MIXL_CTRL][`AMP_EN_BIT]),
        .gain_code(regs[R_MIXL_GAIN][1:0]),
        .amp_on(mixout_l_on),
        .gain(mixout_l_gain)
    );

    // right output mixer amplifier
    output_mixer_channel u_mix_r (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .en_bit(regs[R_MIXR_CTRL][`AMP_EN_BIT]),
        .gain_code(regs[R_MIXR_GAIN][1:0]),
        .amp_on(mixout_r_on),
        .gain(mixout_r_gain)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // checks run on the register clock, quiet in reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // a register write at this edge
    sequence s_wr(logic [7:0] ofs);
        reg_wr_en && reg_addr == ofs;
    endsequence

    // a read of a place with no register
    sequence s_rd_none;
        reg_rd_en && decode_addr(reg_addr) == R_NONE;
    endsequence

    // control bits show the cycle after the write
    property p_amp_enable;
        s_wr(`INPUT_MIXER_TWO_CONTROL_OFS)
            |=> mixin2_amp_on == $past(reg_wdata[`AMP_EN_BIT]);
    endproperty
    a_amp_enable: assert property (p_amp_enable) else $error("amp enable not taken");

    property p_mute;
        s_wr(`INPUT_MIXER_TWO_CONTROL_OFS)
            |=> mixin2_muted == $past(reg_wdata[`MUTE_BIT]);
    endproperty
    a_mute: assert property (p_mute) else $error("mute not taken");

    property p_mixer_sel;
        s_wr(`INPUT_MIXER_TWO_CONTROL_OFS)
            |=> mixin2_mixer_on == $past(reg_wdata[`MIX_SEL_BIT]);
    endproperty
    a_mixer_sel: assert property (p_mixer_sel) else $error("mixer enable not taken");

    // plain gain lands one cycle after the register
    property p_gain_instant;
        s_wr(`INPUT_MIXER_TWO_GAIN_OFS) ##0 !mixin2_gain_busy
            ##0 !regs[R_MIXIN2_CTRL][`RAMP_BIT] ##0 !regs[R_MIXIN2_CTRL][`ZC_BIT]
            |=> ##1 mixin2_gain == $past(reg_wdata[3:0], 2);
    endproperty
    a_gain_instant: assert property (p_gain_instant) else $error("gain not applied in two cycles");

    // output enables pass one flop stage
    property p_left_enable;
        s_wr(`LEFT_OUTPUT_MIXER_CONTROL_OFS)
            |=> ##1 mixout_l_on == $past(reg_wdata[`AMP_EN_BIT], 2);
    endproperty
    a_left_enable: assert property (p_left_enable) else $error("left amp enable late");

    property p_right_enable;
        s_wr(`RIGHT_OUTPUT_MIXER_CONTROL_OFS)
            |=> ##1 mixout_r_on == $past(reg_wdata[`AMP_EN_BIT], 2);
    endproperty
    a_right_enable: assert property (p_right_enable) else $error("right amp enable late");

    // legal gain codes pass, the reserved one holds
    property p_out_gain;
        s_wr(`LEFT_OUTPUT_MIXER_GAIN_OFS) ##0 reg_wdata[1:0] != `MIXOUT_GAIN_RSVD
            |=> ##1 mixout_l_gain == $past(reg_wdata[1:0], 2);
    endproperty
    a_out_gain: assert property (p_out_gain) else $error("left output gain wrong");

    property p_right_gain;
        s_wr(`RIGHT_OUTPUT_MIXER_GAIN_OFS) ##0 reg_wdata[1:0] != `MIXOUT_GAIN_RSVD
            |=> ##1 mixout_r_gain == $past(reg_wdata[1:0], 2);
    endproperty
    a_right_gain: assert property (p_right_gain) else $error("right output gain wrong");

    property p_rsvd_hold;
        s_wr(`LEFT_OUTPUT_MIXER_GAIN_OFS) ##0 reg_wdata[1:0] == `MIXOUT_GAIN_RSVD
            |=> ##1 $stable(mixout_l_gain);
    endproperty
    a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved gain code moved gain");

    // equalizer on brings its attenuation a cycle on
    property p_eq_atten;
        s_wr(`OUTPUT_EQ_BAND_FIVE_ENABLE_OFS) ##0 reg_wdata[`EQ_ON_BIT]
            |=> output_equalizer_on ##1 eq_atten_db == `EQ_ATTEN_DB;
    endproperty
    a_eq_atten: assert property (p_eq_atten) else $error("equalizer attenuation missing");

    // coefficient strobe follows coefficient writes only
    property p_coef_strobe;
        s_wr(`OUTPUT_BIQUAD_COEF_DATA_OFS)
            |=> coef_wr_pulse;
    endproperty
    a_coef_strobe: assert property (p_coef_strobe) else $error("coefficient strobe missing");

    property p_coef_quiet;
        !(reg_wr_en && reg_addr == `OUTPUT_BIQUAD_COEF_DATA_OFS)
            |=> !coef_wr_pulse;
    endproperty
    a_coef_quiet: assert property (p_coef_quiet) else $error("coefficient strobe without write");

    // unmapped places read as zero
    property p_read_back;
        s_rd_none
            |=> reg_rdata_valid && reg_rdata == `ZERO_BYTE;
    endproperty
    a_read_back: assert property (p_read_back) else $error("unmapped read not zero");
endmodule // mixer_gain_control_regs

// File: dv/tb_mixer_gain_control_regs.sv
// self-checking bench for the mixer gain control register bank
`timescale 1ns/1ps
module tb_mixer_gain_control_regs
    import mixer_gain_pkg::*;
;
    localparam int STEP = 2;
    localparam byte_t OFS [13] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2e, 8'h2f,
        8'hcc, 8'hcd, 8'hce, 8'hcf};
    localparam byte_t RST [13] = '{8'h80, 8'h77, 8'h77, 8'h07, 8'h40, 8'h00, 8'h00, 8'h48, 8'h03,
        8'h00, 8'h03, 8'h00, 8'h03};
    localparam byte_t MSK [13] = '{8'hbf, 8'hff, 8'hff, 8'h8f, 8'hc0, 8'hff, 8'h3f, 8'hf8, 8'h0f,
        8'h80, 8'h03, 8'h80, 8'h03};
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic mixin2_zero_cross = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rdata_valid, mixin2_amp_on, mixin2_muted, mixin2_mixer_on, mixin2_gain_busy;
    logic [3:0] mixin2_gain;
    logic mixout_l_on, mixout_r_on, output_equalizer_on, biquad_on, biquad_muted, coef_wr_pulse;
    logic [1:0] mixout_l_gain, mixout_r_gain;
    logic [7:0] highpass_cfg, coef_data;
    logic [19:0] eq_band_codes;
    logic [3:0] eq_atten_db;
    logic [5:0] coef_index;
    int bad_count = 0;
    int checks = 0;
    int seed = 60;
    int mdl [256];
    int msk [256];
    int applied;
    int og;
    int t;

    // ----------------------------------------------------------------
    // clock and device under test
    // ----------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    mixer_gain_control_regs #(.RAMP_STEP_CYCLES(STEP)) i_mixer_gain_control_regs (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .mixin2_zero_cross(mixin2_zero_cross),
        .mixin2_amp_on(mixin2_amp_on), .mixin2_muted(mixin2_muted), .mixin2_mixer_on(mixin2_mixer_on),
        .mixin2_gain(mixin2_gain), .mixin2_gain_busy(mixin2_gain_busy), .mixout_l_on(mixout_l_on),
        .mixout_l_gain(mixout_l_gain), .mixout_r_on(mixout_r_on), .mixout_r_gain(mixout_r_gain),
        .highpass_cfg(highpass_cfg), .eq_band_codes(eq_band_codes),
        .output_equalizer_on(output_equalizer_on), .eq_atten_db(eq_atten_db), .biquad_on(biquad_on),
        .biquad_muted(biquad_muted), .coef_data(coef_data), .coef_index(coef_index),
        .coef_wr_pulse(coef_wr_pulse));

    // ----------------------------------------------------------------
    // compare, bus and reset tasks (called at the falling edge)
    // ----------------------------------------------------------------
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // unmapped places have a zero mask, so writes there leave the model alone
    task automatic wr(input byte_t a, input byte_t d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        chk(coef_wr_pulse, 20'(a == 8'h29), "coef strobe");
        if (msk[a] != 0) mdl[a] = d & msk[a];
        @(negedge core_clk);
    endtask

    task automatic rd(input byte_t a);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        chk(reg_rdata_valid, 20'(1), "read valid");
        chk(reg_rdata, 20'(mdl[a]), "read data");
        @(negedge core_clk);
    endtask

    task automatic reset_all;
        arst_n = 1'b0;
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
        foreach (mdl[i]) begin
            mdl[i] = 0;
            msk[i] = 0;
        end
        for (int k = 0; k < 13; k++) begin
            mdl[OFS[k]] = RST[k];
            msk[OFS[k]] = MSK[k];
        end
        applied = 3;
    endtask

    // ramp towards a target: single code steps, paced by STEP, no early jump
    task automatic ramp_to(input int tg);
        int prev;
        int steps;
        int n;
        prev = applied;
        steps = 0;
        wr(8'h2f, byte_t'(tg));
        for (n = 0; n < 400 && (mixin2_gain !== 4'(tg) || mixin2_gain_busy !== 1'b0); n++) begin
            @(negedge core_clk);
            if (mixin2_gain !== 4'(prev)) begin
                chk(mixin2_gain, 20'(tg > prev ? prev + 1 : prev - 1), "ramp step");
                prev = mixin2_gain;
                steps++;
            end
        end
        if (n == 400) begin
            bad_count++;
            complete_run();
        end
        chk(20'(steps), 20'(tg > applied ? tg - applied : applied - tg), "ramp step count");
        chk(20'(n >= (steps - 1) * STEP && n <= (steps + 1) * STEP + 4), 20'(1), "ramp pacing");
        applied = tg;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_all();
        chk(mixin2_amp_on, 20'(0), "amp after reset");
        chk(mixin2_muted, 20'(1), "mute after reset");
        chk(mixin2_mixer_on, 20'(1), "mixer after reset");
        chk(mixin2_gain, 20'(3), "gain after reset");
        chk({mixout_l_on, mixout_r_on, mixout_l_gain, mixout_r_gain}, 20'h0f, "out mixers after reset");
        for (int k = 0; k < 13; k++) rd(OFS[k]);
        wr(8'h30, 8'hff);
        rd(8'h30);
        // random filter setup and output amplifier enables
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 7; k++) wr(OFS[k], byte_t'($random(seed)) & MSK[k]);
            wr(8'hcc, byte_t'($random(seed)) & 8'h80);
            wr(8'hce, byte_t'($random(seed)) & 8'h80);
            @(negedge core_clk);
            chk(highpass_cfg, 20'(mdl[8'h24]), "highpass setup");
            chk(eq_band_codes, {4'(mdl[8'h27]), 8'(mdl[8'h26]), 8'(mdl[8'h25])}, "eq bands");
            chk(output_equalizer_on, 20'(mdl[8'h27][7]), "eq on");
            chk(eq_atten_db, 20'(mdl[8'h27][7] ? 12 : 0), "eq attenuation");
            chk({biquad_on, biquad_muted}, 20'(mdl[8'h28][7:6]), "biquad ctrl");
            chk({coef_data, 2'b00, coef_index}, 20'({mdl[8'h29][7:0], mdl[8'h2a][7:0]}), "coef");
            chk(mixout_l_on, 20'(mdl[8'hcc][7]), "left enable");
            chk(mixout_r_on, 20'(mdl[8'hce][7]), "right enable");
            for (int k = 0; k < 7; k++) rd(OFS[k]);
        end
        // output gain codes, reserved code keeps the previous gain
        og = 3;
        for (int c = 1; c < 9; c++) begin
            t = c % 4;
            wr(8'hcd, byte_t'(t));
            wr(8'hcf, byte_t'(t));
            if (t != 0) og = t;
            @(negedge core_clk);
            chk(mixout_l_gain, 20'(og), "left gain");
            chk(mixout_r_gain, 20'(og), "right gain");
            rd(8'hcd);
        end
        // input mixer two control bits, ramp and zero cross kept clear
        for (int i = 0; i < 8; i++) begin
            wr(8'h2e, byte_t'($random(seed) & 8'hc8));
            chk(mixin2_amp_on, 20'(mdl[8'h2e][7]), "amp enable");
            chk(mixin2_muted, 20'(mdl[8'h2e][6]), "mute");
            chk(mixin2_mixer_on, 20'(mdl[8'h2e][3]), "mixer enable");
            rd(8'h2e);
        end
        // every gain code applied at once
        for (int i = 0; i < 16; i++) begin
            t = (i * 7 + 5) % 16;
            wr(8'h2f, byte_t'(t));
            @(negedge core_clk);
            chk(mixin2_gain, 20'(t), "immediate gain");
            chk(mixin2_gain_busy, 20'(0), "immediate idle");
            applied = t;
        end
        // zero cross wait
        wr(8'h2e, 8'h90);
        t = applied ^ 5;
        wr(8'h2f, byte_t'(t));
        chk(mixin2_gain_busy, 20'(1), "zero cross wait");
        repeat (4) @(negedge core_clk);
        chk(mixin2_gain, 20'(applied), "gain held until zero cross");
        mixin2_zero_cross = 1'b1;
        @(negedge core_clk);
        mixin2_zero_cross = 1'b0;
        chk(mixin2_gain, 20'(t), "gain at zero cross");
        applied = t;
        // ramp with zero cross also set
        wr(8'h2e, 8'hb0);
        ramp_to(13);
        ramp_to(2);
        rd(8'h2f);
        // second reset mid-run
        reset_all();
        chk(mixin2_gain, 20'(3), "gain after second reset");
        rd(8'h2e);
        rd(8'hcd);
        complete_run();
    end
endmodule // tb_mixer_gain_control_regs
